// ### hw/apsc_defs.svh
// Constants for the amplifier protection and start-up controller:
// register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef APSC_DEFS_SVH
`define APSC_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define APSC_CTRL_OFS 12'h000
`define APSC_STATUS_OFS 12'h004
`define APSC_IRQ_STATUS_OFS 12'h008
`define APSC_IRQ_MASK_OFS 12'h00c

// ****************************************************************
// Field positions
// ****************************************************************
// Control: six-channel mode when set, three-channel mode when clear
`define APSC_CTRL_SIX_CH_BIT 0
// Live status
`define APSC_ST_UNDERVOLT_BIT 0
`define APSC_ST_THERMAL_SD_BIT 1
`define APSC_ST_OVERLOAD_BIT 2
`define APSC_ST_THERMAL_WARN_BIT 3
`define APSC_ST_RESET_PIN_BIT 4
`define APSC_ST_FAULT_PIN_BIT 5
`define APSC_ST_WARN_PIN_BIT 6
`define APSC_ST_RUNNING_BIT 7
// Interrupt status and mask share one layout
`define APSC_IRQ_UNDERVOLT_BIT 0
`define APSC_IRQ_THERMAL_SD_BIT 1
`define APSC_IRQ_OVERLOAD_BIT 2
`define APSC_IRQ_THERMAL_WARN_BIT 3
`define APSC_IRQ_WIDTH 4

// ****************************************************************
// Reset values
// ****************************************************************
`define APSC_CTRL_RESET 1'b1
`define APSC_IRQ_MASK_RESET 4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define APSC_CLK_PERIOD_NS 50
`define APSC_OC_PERSIST_NS 1000
`define APSC_OC_PERSIST_CYC ((`APSC_OC_PERSIST_NS + `APSC_CLK_PERIOD_NS - 1) / `APSC_CLK_PERIOD_NS)

`endif

// ### hw/apsc_pkg.sv
// Types shared by the protection controller and its pin synchroniser.
// Assumes the constants header sits beside it.
`include "apsc_defs.svh"

package apsc_pkg;

  typedef logic [31:0] apsc_word_t;
  typedef logic [11:0] apsc_addr_t;

  // Power-up hold, normal run, latched overload
  typedef enum logic [2:0] {
    ST_POR = 3'b001,
    ST_RUN = 3'b010,
    ST_OVERLOAD = 3'b100
  } apsc_state_e;

endpackage

// ### hw/apsc_pin_if.sv
// Bundle of synchronised control pins and monitor flags.
// Assumes one clock domain; the synchroniser drives, the controller reads.
`timescale 1ns/1ns

interface apsc_pin_if #(
  parameter int NUM_GATE_SUPPLY = 3
);
  logic reset_pin_n;
  logic bias_mode_select;
  logic [NUM_GATE_SUPPLY-1:0] gate_drive_supply_ok;
  logic logic_supply_ok;
  logic overcurrent;
  logic thermal_shutdown;
  logic thermal_warn;

  modport sync_side (
    output reset_pin_n,
    output bias_mode_select,
    output gate_drive_supply_ok,
    output logic_supply_ok,
    output overcurrent,
    output thermal_shutdown,
    output thermal_warn
  );

  modport ctrl_side (
    input reset_pin_n,
    input bias_mode_select,
    input gate_drive_supply_ok,
    input logic_supply_ok,
    input overcurrent,
    input thermal_shutdown,
    input thermal_warn
  );
endinterface

// ### hw/apsc_pin_sync.sv
// Two-stage synchroniser for the host pins and monitor flags.
// Assumes raw inputs may change at any time relative to pclk.
`timescale 1ns/1ns

module apsc_pin_sync #(
  parameter int NUM_GATE_SUPPLY = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_GATE_SUPPLY+5:0] raw,
  apsc_pin_if.sync_side pins
);
  import apsc_pkg::*;

  localparam int W = NUM_GATE_SUPPLY + 6;

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Stage one feeds stage two only; reset pin and supplies start low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  // Unpack in the order the controller packs
  assign pins.reset_pin_n = sync_q[0];
  assign pins.bias_mode_select = sync_q[1];
  assign pins.logic_supply_ok = sync_q[2];
  assign pins.overcurrent = sync_q[3];
  assign pins.thermal_shutdown = sync_q[4];
  assign pins.thermal_warn = sync_q[5];
  assign pins.gate_drive_supply_ok = sync_q[W-1:6];

endmodule

// ### hw/apsc_ctrl.sv
// Protection and start-up controller for a six-channel switching power stage.
// Assumes an APB master on pclk, open-drain pads outside and analog flags as levels.
//
// Functional notes
// - Power-on reset clears overload latch; hold inactive until all supplies good.
// - Any single supply undervoltage forces all bridges off and fault low.
// - Recovery from undervoltage is automatic once all supplies are good.
// - Reset pin low forces every half-bridge output off.
// - Reset pin low releases the fault output high regardless of faults.
// - Overload latch clears only on reset pin rising edge from host.
// - Six-channel mode: 00 all off, 10 bias only, 11 all channels.
// - Three-channel mode: 01 channels A-C only, 10 bias only, 00 off.
// - Fault and warning outputs active low; warning follows thermal warning flag; the code releases it high while reset pin low.
// - Persistent overcurrent latches shutdown; undervoltage and thermal recover alone.
// - Thermal shutdown flag forces all bridges off and fault low.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "apsc_defs.svh"

module apsc_ctrl #(
  parameter int NUM_GATE_SUPPLY = 3,
  parameter int OC_PERSIST_CYC = `APSC_OC_PERSIST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire apsc_pkg::apsc_addr_t paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire apsc_pkg::apsc_word_t pwdata,
  output apsc_pkg::apsc_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic bias_mode_select,
  input wire logic [NUM_GATE_SUPPLY-1:0] gate_drive_supply_ok,
  input wire logic logic_supply_ok,
  input wire logic overcurrent_flag,
  input wire logic thermal_shutdown,
  input wire logic thermal_warn_flag,
  output logic out_a2c_active,
  output logic out_def_active,
  output logic bias_precharge_ctrl,
  output logic shutdown_fault_n,
  output logic shutdown_fault_n_en,
  input wire logic shutdown_fault_n_pin,
  output logic thermal_warn_n,
  output logic thermal_warn_n_en,
  input wire logic thermal_warn_n_pin,
  output logic irq
);
  import apsc_pkg::*;

  // Counter wide enough to hold the persistence limit itself
  localparam int CW = $clog2(OC_PERSIST_CYC + 1);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************

  // Synced copies of pins and flags; below, only the two pad readbacks in the status word are read raw
  apsc_pin_if #(.NUM_GATE_SUPPLY(NUM_GATE_SUPPLY)) pins ();

  apsc_pin_sync #(
    .NUM_GATE_SUPPLY(NUM_GATE_SUPPLY)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({gate_drive_supply_ok, thermal_warn_flag, thermal_shutdown, overcurrent_flag,
          logic_supply_ok, bias_mode_select, reset_pin_n}),
    .pins(pins)
  );

  // ****************************************************************
  // Protection state
  // ****************************************************************

  apsc_state_e state_q;
  logic reset_pin_prev_q;
  logic reset_rise;
  logic undervolt;
  logic oc_persist;
  logic [CW-1:0] oc_cnt_q;
  logic overload_latch;
  logic six_ch_mode_q;

  // each supply judged on its own
  // Any one low supply is enough; no voting between them
  assign undervolt = !(&pins.gate_drive_supply_ok) || !pins.logic_supply_ok;

  // edge found on the synced pin
  assign reset_rise = pins.reset_pin_n && !reset_pin_prev_q;

  // Previous synced reset level, for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_prev_q <= 1'b0;
    end else begin
      reset_pin_prev_q <= pins.reset_pin_n;
    end
  end

  // overcurrent must persist
  // Short bursts are the current limiter's business, not a shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cnt_q <= '0;
    end else if (!pins.overcurrent || state_q != ST_RUN) begin
      oc_cnt_q <= '0;
    end else if (!oc_persist) begin
      oc_cnt_q <= oc_cnt_q + CW'(1);
    end
  end

  // Counter stops at the limit, so the flag holds until the burst ends or the state leaves ST_RUN
  assign oc_persist = (oc_cnt_q >= CW'(OC_PERSIST_CYC));

  // power-up hold, latched overload
  // Latch leaves only on a reset rise; the rise wins even if overcurrent is still high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_POR;
    end else begin
      unique case (state_q)
        ST_POR: begin
          // wait for every supply
          // Reset pin ignored here; its edge only matters in overload
          if (!undervolt) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (oc_persist) begin
            state_q <= ST_OVERLOAD;
          end
        end
        ST_OVERLOAD: begin
          if (reset_rise) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_POR;
        end
      endcase
    end
  end

  // Latch is a state, so power-on reset clears it with the rest
  assign overload_latch = (state_q == ST_OVERLOAD);

  // ****************************************************************
  // Output gating
  // ****************************************************************

  logic fault;
  logic bridges_ok;
  logic a2c_d;
  logic def_d;
  logic bias_d;
  logic fault_low_d;
  logic warn_low_d;

  // undervoltage and thermal clear on their own
  assign fault = undervolt || pins.thermal_shutdown || overload_latch;
  assign bridges_ok = (state_q != ST_POR) && !fault;

  // Pin decode by mode and select/reset pins
  always_comb begin
    a2c_d = 1'b0;
    def_d = 1'b0;
    bias_d = 1'b0;
    if (bridges_ok) begin
      if (!pins.reset_pin_n) begin
        // bridges off while reset low; bias only on select high
        bias_d = pins.bias_mode_select;
      end else if (six_ch_mode_q) begin
        a2c_d = pins.bias_mode_select;
        def_d = pins.bias_mode_select;
      end else begin
        a2c_d = !pins.bias_mode_select;
      end
    end
  end

  // fault pin low on shutdown; released while reset low
  assign fault_low_d = pins.reset_pin_n && (fault || state_q == ST_POR);
  assign warn_low_d = pins.reset_pin_n && pins.thermal_warn;

  // Registered drivers for the power stage and pads
  // Flops keep decode hazards off the gate drivers and open-drain pads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a2c_active <= 1'b0;
      out_def_active <= 1'b0;
      bias_precharge_ctrl <= 1'b0;
      shutdown_fault_n <= 1'b1;
      thermal_warn_n <= 1'b1;
    end else begin
      out_a2c_active <= a2c_d;
      out_def_active <= def_d;
      bias_precharge_ctrl <= bias_d;
      shutdown_fault_n <= !fault_low_d;
      thermal_warn_n <= !warn_low_d;
    end
  end

  // open drain: drive only when low
  assign shutdown_fault_n_en = !shutdown_fault_n;
  assign thermal_warn_n_en = !thermal_warn_n;

  // ****************************************************************
  // Event capture
  // ****************************************************************

  logic [`APSC_IRQ_WIDTH-1:0] ev_level;
  logic [`APSC_IRQ_WIDTH-1:0] ev_prev_q;
  logic [`APSC_IRQ_WIDTH-1:0] ev_pulse;
  logic [`APSC_IRQ_WIDTH-1:0] irq_status_q;
  logic [`APSC_IRQ_WIDTH-1:0] irq_mask_q;
  logic [`APSC_IRQ_WIDTH-1:0] w1c;

  // Event sources as levels; an event is each rising edge
  always_comb begin
    ev_level = '0;
    ev_level[`APSC_IRQ_UNDERVOLT_BIT] = undervolt && (state_q != ST_POR);
    ev_level[`APSC_IRQ_THERMAL_SD_BIT] = pins.thermal_shutdown;
    ev_level[`APSC_IRQ_OVERLOAD_BIT] = overload_latch;
    ev_level[`APSC_IRQ_THERMAL_WARN_BIT] = pins.thermal_warn;
  end

  // Previous levels; cleared, so a flag already high at reset counts once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_prev_q <= '0;
    end else begin
      ev_prev_q <= ev_level;
    end
  end

  // One pulse per rise; a flag stuck high raises its bit only once
  assign ev_pulse = ev_level & ~ev_prev_q;

  // ****************************************************************
  // APB slave
  // ****************************************************************

  logic setup;
  logic access;
  logic wr_en;
  logic hit;
  apsc_word_t rd_val;
  apsc_word_t status_word;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_en = access && pwrite;

  // Only the four words decode; anything else answers with an error
  assign hit = (paddr == `APSC_CTRL_OFS) || (paddr == `APSC_STATUS_OFS) ||
               (paddr == `APSC_IRQ_STATUS_OFS) || (paddr == `APSC_IRQ_MASK_OFS);

  // Live state for software
  // Pad readbacks show what the line really does, pull-up included
  always_comb begin
    status_word = '0;
    status_word[`APSC_ST_UNDERVOLT_BIT] = undervolt;
    status_word[`APSC_ST_THERMAL_SD_BIT] = pins.thermal_shutdown;
    status_word[`APSC_ST_OVERLOAD_BIT] = overload_latch;
    status_word[`APSC_ST_THERMAL_WARN_BIT] = pins.thermal_warn;
    status_word[`APSC_ST_RESET_PIN_BIT] = pins.reset_pin_n;
    status_word[`APSC_ST_FAULT_PIN_BIT] = shutdown_fault_n_pin;
    status_word[`APSC_ST_WARN_PIN_BIT] = thermal_warn_n_pin;
    status_word[`APSC_ST_RUNNING_BIT] = (state_q == ST_RUN);
  end

  // Read mux, sampled in the setup cycle
  always_comb begin
    rd_val = '0;
    unique case (paddr)
      `APSC_CTRL_OFS: rd_val[`APSC_CTRL_SIX_CH_BIT] = six_ch_mode_q;
      `APSC_STATUS_OFS: rd_val = status_word;
      `APSC_IRQ_STATUS_OFS: rd_val[`APSC_IRQ_WIDTH-1:0] = irq_status_q;
      `APSC_IRQ_MASK_OFS: rd_val[`APSC_IRQ_WIDTH-1:0] = irq_mask_q;
      default: rd_val = '0;
    endcase
  end

  // Read data and error latched at setup so they stand through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      // Writes return zero so stale read data never leaks
      prdata <= pwrite ? '0 : rd_val;
      pslverr <= !hit;
    end
  end

  // Mode selection, steers the channel decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      six_ch_mode_q <= `APSC_CTRL_RESET;
    end else if (wr_en && paddr == `APSC_CTRL_OFS) begin
      six_ch_mode_q <= pwdata[`APSC_CTRL_SIX_CH_BIT];
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `APSC_IRQ_MASK_RESET;
    end else if (wr_en && paddr == `APSC_IRQ_MASK_OFS) begin
      irq_mask_q <= pwdata[`APSC_IRQ_WIDTH-1:0];
    end
  end

  // Clear strobe only on a write to the interrupt status word
  assign w1c = (wr_en && paddr == `APSC_IRQ_STATUS_OFS) ? pwdata[`APSC_IRQ_WIDTH-1:0] : '0;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~w1c) | ev_pulse;
    end
  end

  // Level interrupt while any unmasked bit stands
  assign irq = |(irq_status_q & irq_mask_q);

endmodule

// ### tb/apsc_ctrl_chk.sv
// Concurrent checks on the protection controller's pin-side ports.
// Assumes a pin change reaches the outputs three edges after it is sampled.
`timescale 1ns/1ns

module apsc_ctrl_chk #(
  parameter int NUM_GATE_SUPPLY = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire logic [NUM_GATE_SUPPLY-1:0] gate_drive_supply_ok,
  input wire logic logic_supply_ok,
  input wire logic thermal_shutdown,
  input wire logic thermal_warn_flag,
  input wire logic out_a2c_active,
  input wire logic out_def_active,
  input wire logic bias_precharge_ctrl,
  input wire logic shutdown_fault_n,
  input wire logic shutdown_fault_n_en,
  input wire logic thermal_warn_n
);
  import apsc_pkg::*;

  // ****************************************
  // Pin relations
  // ****************************************
  // A cause held four samples has surely reached the outputs
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire supply_low = !(&gate_drive_supply_ok) || !logic_supply_ok;
  wire bridges_off = !out_a2c_active && !out_def_active;

  a_reset_bridges_off: assert property (!reset_pin_n [*4] |-> bridges_off)
    else $error("bridges active with reset pin low");
  a_reset_fault_high: assert property (!reset_pin_n [*4] |-> shutdown_fault_n && thermal_warn_n)
    else $error("fault or warning low with reset pin low");
  a_uv_all_off: assert property (supply_low [*4] |-> bridges_off && !bias_precharge_ctrl)
    else $error("output active during undervoltage");
  a_uv_fault_low: assert property ((supply_low && reset_pin_n) [*4] |-> !shutdown_fault_n)
    else $error("undervoltage not signalled");
  a_thermal_sd_off: assert property ((thermal_shutdown && reset_pin_n) [*4] |-> bridges_off && !shutdown_fault_n)
    else $error("thermal shutdown not obeyed");
  a_warn_follows: assert property ((thermal_warn_flag && reset_pin_n) [*4] |-> !thermal_warn_n)
    else $error("warning output not low");
  a_warn_idle: assert property (!thermal_warn_flag [*4] |-> thermal_warn_n)
    else $error("warning low without warning flag");
  a_fault_drive: assert property (!shutdown_fault_n |-> shutdown_fault_n_en && $past(reset_pin_n, 3))
    else $error("fault pad low without reset pin high");
  a_bias_exclusive: assert property (bias_precharge_ctrl |-> bridges_off)
    else $error("bias active while channels switch");
  a_def_needs_a2c: assert property (out_def_active |-> out_a2c_active)
    else $error("channels D-F without A-C");
  a_start_cause: assert property ($rose(out_a2c_active) |-> $past(reset_pin_n, 3) && !$past(supply_low, 3))
    else $error("channels started without cause");
endmodule

bind apsc_ctrl apsc_ctrl_chk #(.NUM_GATE_SUPPLY(NUM_GATE_SUPPLY)) apsc_ctrl_chk_inst (.pclk, .presetn,
  .reset_pin_n, .gate_drive_supply_ok, .logic_supply_ok, .thermal_shutdown, .thermal_warn_flag,
  .out_a2c_active, .out_def_active, .bias_precharge_ctrl, .shutdown_fault_n, .shutdown_fault_n_en,
  .thermal_warn_n);

// ### tb/apsc_host_model.sv
// Host sequencer model driving the reset and select pins.
// Assumes the bench only asks it to run or to stop.
`timescale 1ns/1ns

module apsc_host_model #(
  parameter int PRE_CYC = 10
) (
  input wire logic pclk,
  input wire logic want_run,
  input wire logic six_mode,
  output logic reset_pin_n,
  output logic bias_mode_select
);
  int cnt_q = 0;
  logic rst_q = 1'b0;
  logic sel_q = 1'b0;

  // Stop holds both pins low; start precharges the bias before release
  // pin sequencing
  always @(posedge pclk) begin
    if (!want_run) begin
      cnt_q <= 0;
      rst_q <= 1'b0;
      sel_q <= 1'b0;
    end else if (cnt_q < PRE_CYC) begin
      cnt_q <= cnt_q + 1;
      rst_q <= 1'b0;
      sel_q <= 1'b1;
    end else begin
      rst_q <= 1'b1;
      sel_q <= six_mode;
    end
  end
  assign reset_pin_n = rst_q;
  assign bias_mode_select = sel_q;
endmodule

// ### tb/apsc_ctrl_tb_top.sv
// Self-checking bench: APB register access plus pin-level protection scenarios.
// Assumes the checker binds itself and the fault pads have pull-ups.
`timescale 1ns/1ns
`include "apsc_defs.svh"

module apsc_ctrl_tb_top;
  import apsc_pkg::*;
  localparam int PRE = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apsc_addr_t paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  apsc_word_t pwdata = '0;
  apsc_word_t prdata;
  logic pready, pslverr, reset_pin_n, bias_mode_select, irq;
  logic [2:0] gate_drive_supply_ok = 3'h7;
  logic logic_supply_ok = 1'b1;
  logic overcurrent_flag = 1'b0;
  logic thermal_shutdown = 1'b0;
  logic thermal_warn_flag = 1'b0;
  logic want_run = 1'b0;
  logic six_mode = 1'b1;
  logic out_a2c_active, out_def_active, bias_precharge_ctrl;
  logic shutdown_fault_n, shutdown_fault_n_en, thermal_warn_n, thermal_warn_n_en;
  // Open-drain pads with pull-ups
  wire shutdown_fault_n_pin = shutdown_fault_n_en ? 1'b0 : 1'b1;
  wire thermal_warn_n_pin = thermal_warn_n_en ? 1'b0 : 1'b1;
  apsc_word_t rv;
  logic ev;
  int fails = 0;
  int comparisons = 0;

  apsc_ctrl #(.OC_PERSIST_CYC(2)) apsc_ctrl_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .reset_pin_n, .bias_mode_select, .gate_drive_supply_ok,
    .logic_supply_ok, .overcurrent_flag, .thermal_shutdown, .thermal_warn_flag, .out_a2c_active,
    .out_def_active, .bias_precharge_ctrl, .shutdown_fault_n, .shutdown_fault_n_en, .shutdown_fault_n_pin,
    .thermal_warn_n, .thermal_warn_n_en, .thermal_warn_n_pin, .irq);
  apsc_host_model #(.PRE_CYC(PRE)) apsc_host_model_inst (.pclk, .want_run, .six_mode, .reset_pin_n,
    .bias_mode_select);

  initial forever #25 pclk = ~pclk;

  task check(input string name, input apsc_word_t seen, input apsc_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One APB transfer; the wait on pready is bounded
  task apb(input logic w, input apsc_addr_t a, input apsc_word_t d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task step(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Sample {irq, warn_n, bias, a2c, d2f, fault_n} once settled
  task probe(input string name, input logic [5:0] exp);
    #1;
    check(name, {irq, thermal_warn_n, bias_precharge_ctrl, out_a2c_active, out_def_active, shutdown_fault_n}, exp);
    @(posedge pclk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    step(3);
    presetn <= 1'b1;
    step(1);
    apb(1'b0, `APSC_CTRL_OFS, '0);
    check("ctrl reset", rv, 32'h1);
    apb(1'b0, `APSC_IRQ_MASK_OFS, '0);
    check("mask reset", rv, 32'h0);
    apb(1'b1, `APSC_IRQ_MASK_OFS, 32'hf);
    apb(1'b0, `APSC_IRQ_MASK_OFS, '0);
    check("mask rw", rv, 32'hf);
    apb(1'b0, 12'h010, '0);
    check("unmapped", {ev, rv[30:0]}, 32'h8000_0000);
    probe("idle", 6'b010001);
    $display("test registers done");
    want_run <= 1'b1;
    step(7);
    probe("six bias", 6'b011001);
    step(PRE + 2);
    probe("six run", 6'b010111);
    $display("test six mode done");
    gate_drive_supply_ok <= 3'h5;
    step(2);
    probe("uv sync", 6'b010111);
    step(3);
    probe("uv off", 6'b110000);
    gate_drive_supply_ok <= 3'h7;
    step(6);
    probe("uv back", 6'b110111);
    apb(1'b0, `APSC_IRQ_STATUS_OFS, '0);
    check("uv irq", rv[3:0], 4'h1);
    apb(1'b1, `APSC_IRQ_STATUS_OFS, 32'h1);
    probe("uv clear", 6'b010111);
    $display("test undervoltage done");
    apb(1'b1, `APSC_IRQ_MASK_OFS, 32'h0);
    thermal_warn_flag <= 1'b1;
    step(6);
    probe("warn", 6'b000111);
    apb(1'b0, `APSC_IRQ_STATUS_OFS, '0);
    check("warn irq", rv[3:0], 4'h8);
    apb(1'b1, `APSC_IRQ_MASK_OFS, 32'h8);
    probe("warn unmask", 6'b100111);
    apb(1'b1, `APSC_IRQ_STATUS_OFS, 32'h8);
    probe("warn clear", 6'b000111);
    thermal_warn_flag <= 1'b0;
    thermal_shutdown <= 1'b1;
    step(6);
    probe("tsd off", 6'b010000);
    thermal_shutdown <= 1'b0;
    step(6);
    probe("tsd back", 6'b010111);
    apb(1'b1, `APSC_IRQ_STATUS_OFS, 32'hf);
    $display("test thermal done");
    apb(1'b1, `APSC_IRQ_MASK_OFS, 32'h4);
    overcurrent_flag <= 1'b1;
    step(8);
    overcurrent_flag <= 1'b0;
    step(6);
    probe("ovl off", 6'b110000);
    step(10);
    probe("ovl held", 6'b110000);
    want_run <= 1'b0;
    step(6);
    probe("ovl reset low", 6'b110001);
    apb(1'b0, `APSC_STATUS_OFS, '0);
    check("ovl status", rv, 32'h64);
    want_run <= 1'b1;
    step(PRE + 9);
    probe("ovl restart", 6'b110111);
    apb(1'b1, `APSC_IRQ_STATUS_OFS, 32'hf);
    probe("ovl clear", 6'b010111);
    $display("test overload done");
    apb(1'b1, `APSC_CTRL_OFS, 32'h0);
    six_mode <= 1'b0;
    want_run <= 1'b0;
    step(6);
    probe("three off", 6'b010001);
    want_run <= 1'b1;
    step(7);
    probe("three bias", 6'b011001);
    step(PRE + 2);
    probe("three run", 6'b010101);
    $display("test three mode done");
    // Mid-run reset with a supply low: hold in power-up until it returns
    presetn <= 1'b0;
    step(2);
    presetn <= 1'b1;
    logic_supply_ok <= 1'b0;
    six_mode <= 1'b1;
    step(6);
    probe("por hold", 6'b010000);
    apb(1'b0, `APSC_STATUS_OFS, '0);
    check("por status", rv, 32'h51);
    apb(1'b0, `APSC_CTRL_OFS, '0);
    check("ctrl re-reset", rv, 32'h1);
    logic_supply_ok <= 1'b1;
    step(6);
    probe("por release", 6'b010111);
    $display("test power-on hold done");
    give_verdict();
  end
endmodule
